//--- logic/gdt_regs.v
// register bank for freewheel timing, peak drive current and delay targets
// assumes a serial front end giving one-cycle write/read strobes on clk
`timescale 1ns/1ns
`include "gdt_consts.vh"

module gdt_regs #(
	parameter [15:0] PART_ID = 16'h00a5 // arbitrary identification value
)
(
	clk,
	rst,
	regBankSel,
	regAddr,
	regWrData,
	regWrEn,
	regRdEn,
	regRdData,
	regHit,
	measDelayCh,
	measEdgeCh,
	measLoad,
	genStatusIn,
	dsovIn,
	hbvoutIn,
	freewheelBlankTimeSlot4,
	freewheelCrosscurrentTimeSlot4,
	freewheelBlankTimeSlot3,
	peakDriveCurrentCh1,
	peakDriveCurrentCh2,
	peakDriveCurrentCh3,
	chargePhaseCh,
	activeCurrentCh,
	turnoffDelayTargetCh1,
	turnoffDelayTargetCh2,
	turnoffDelayTargetCh3,
	turnonDelayTargetCh1,
	turnonDelayTargetCh2,
	turnonDelayTargetCh3
);
	input wire clk;
	input wire rst;
	input wire regBankSel;
	input wire [4:0] regAddr;
	input wire [15:0] regWrData;
	input wire regWrEn;
	input wire regRdEn;
	output reg [15:0] regRdData;
	output reg regHit;
	input wire [47:0] measDelayCh;
	input wire [47:0] measEdgeCh;
	input wire [2:0] measLoad;
	input wire [15:0] genStatusIn;
	input wire [15:0] dsovIn;
	input wire [15:0] hbvoutIn;
	output wire [2:0] freewheelBlankTimeSlot4;
	output wire [2:0] freewheelCrosscurrentTimeSlot4;
	output wire [2:0] freewheelBlankTimeSlot3;
	output wire [1:0] peakDriveCurrentCh1;
	output wire [1:0] peakDriveCurrentCh2;
	output wire [1:0] peakDriveCurrentCh3;
	input wire [2:0] chargePhaseCh;
	output reg [5:0] activeCurrentCh;
	output wire [7:0] turnoffDelayTargetCh1;
	output wire [7:0] turnoffDelayTargetCh2;
	output wire [7:0] turnoffDelayTargetCh3;
	output wire [7:0] turnonDelayTargetCh1;
	output wire [7:0] turnonDelayTargetCh2;
	output wire [7:0] turnonDelayTargetCh3;

	// ***************************************************
	// register storage; only fwTiming_ff and dly_ff are writable
	// ***************************************************
	reg [15:0] fwTiming_ff;
	reg [15:0] dly_ff [0:2];
	reg [15:0] mDly_ff [0:2];
	reg [15:0] mEdge_ff [0:2];
	wire fwSel;
	wire [1:0] dlyIdx;
	wire dlySel;
	reg [15:0] nxt_rdData;
	reg nxt_hit;
	reg [5:0] nxt_activeCurrent;
	// separate loop variables so each process owns its own
	integer i;
	integer k;

	// freewheel register only visible with bank select high
	assign fwSel = (regAddr == `GDT_OFF_FW_TIMING) && regBankSel;
	assign dlySel = (regAddr >= `GDT_OFF_DLY_CH1) && (regAddr <= `GDT_OFF_DLY_CH3);
	assign dlyIdx = (regAddr == `GDT_OFF_DLY_CH1) ? 2'd0 :
		(regAddr == `GDT_OFF_DLY_CH2) ? 2'd1 : 2'd2;

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			fwTiming_ff <= `GDT_RST_FW_TIMING;
			for (i = 0; i < 3; i = i + 1)
			begin
				dly_ff[i] <= `GDT_RST_DLY;
			end
		end
		else if (regWrEn)
		begin
			if (fwSel)
			begin
				fwTiming_ff <= regWrData & `GDT_FW_WRITE_MASK;
			end
			if (dlySel)
			begin
				dly_ff[dlyIdx] <= regWrData;
			end
		end
	end

	// ***************************************************
	// measured status capture
	// ***************************************************
	// measurement logic outside loads results; software cannot write them
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (k = 0; k < 3; k = k + 1)
			begin
				mDly_ff[k] <= `GDT_RST_STATUS;
				mEdge_ff[k] <= `GDT_RST_STATUS;
			end
		end
		else
		begin
			for (k = 0; k < 3; k = k + 1)
			begin
				if (measLoad[k])
				begin
					mDly_ff[k] <= measDelayCh[k*16 +: 16];
					mEdge_ff[k] <= measEdgeCh[k*16 +: 16];
				end
			end
		end
	end

	// ***************************************************
	// field outputs
	// ***************************************************
	assign freewheelBlankTimeSlot4 = fwTiming_ff[`GDT_BLK4_MSB:`GDT_BLK4_LSB];
	assign freewheelCrosscurrentTimeSlot4 = fwTiming_ff[`GDT_CCP4_MSB:`GDT_CCP4_LSB];
	assign freewheelBlankTimeSlot3 = fwTiming_ff[`GDT_BLK3_MSB:`GDT_BLK3_LSB];
	assign peakDriveCurrentCh1 = fwTiming_ff[1:0];
	assign peakDriveCurrentCh2 = fwTiming_ff[3:2];
	assign peakDriveCurrentCh3 = fwTiming_ff[5:4];
	assign turnoffDelayTargetCh1 = dly_ff[0][`GDT_TOFF_MSB:`GDT_TOFF_LSB];
	assign turnoffDelayTargetCh2 = dly_ff[1][`GDT_TOFF_MSB:`GDT_TOFF_LSB];
	assign turnoffDelayTargetCh3 = dly_ff[2][`GDT_TOFF_MSB:`GDT_TOFF_LSB];
	assign turnonDelayTargetCh1 = dly_ff[0][`GDT_TON_MSB:`GDT_TON_LSB];
	assign turnonDelayTargetCh2 = dly_ff[1][`GDT_TON_MSB:`GDT_TON_LSB];
	assign turnonDelayTargetCh3 = dly_ff[2][`GDT_TON_MSB:`GDT_TON_LSB];

	// ***************************************************
	// drive current selection
	// ***************************************************
	// outside the pre/post phases the current select reads 00 (lowest)
	always @*
	begin
		nxt_activeCurrent = 6'h00;
		if (chargePhaseCh[0])
		begin
			nxt_activeCurrent[1:0] = fwTiming_ff[1:0];
		end
		if (chargePhaseCh[1])
		begin
			nxt_activeCurrent[3:2] = fwTiming_ff[3:2];
		end
		if (chargePhaseCh[2])
		begin
			nxt_activeCurrent[5:4] = fwTiming_ff[5:4];
		end
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			activeCurrentCh <= 6'h00;
		end
		else
		begin
			activeCurrentCh <= nxt_activeCurrent;
		end
	end

	// ***************************************************
	// read path
	// ***************************************************
	// decode stays combinational; only the answer is registered
	always @*
	begin
		nxt_rdData = 16'h0000;
		nxt_hit = 1'b1;
		case (regAddr)
			`GDT_OFF_FW_TIMING:
			begin
				if (regBankSel)
				begin
					nxt_rdData = fwTiming_ff & `GDT_FW_WRITE_MASK;
				end
				else
				begin
					nxt_hit = 1'b0;
				end
			end
			`GDT_OFF_DLY_CH1:
			begin
				nxt_rdData = dly_ff[0];
			end
			`GDT_OFF_DLY_CH2:
			begin
				nxt_rdData = dly_ff[1];
			end
			`GDT_OFF_DLY_CH3:
			begin
				nxt_rdData = dly_ff[2];
			end
			`GDT_OFF_GENERAL_STATUS:
			begin
				nxt_rdData = genStatusIn;
			end
			`GDT_OFF_DRAIN_SOURCE_OVERVOLTAGE:
			begin
				nxt_rdData = dsovIn;
			end
			`GDT_OFF_HBVOUT:
			begin
				nxt_rdData = hbvoutIn;
			end
			`GDT_OFF_MDLY_CH1:
			begin
				nxt_rdData = mDly_ff[0];
			end
			`GDT_OFF_MDLY_CH2:
			begin
				nxt_rdData = mDly_ff[1];
			end
			`GDT_OFF_MDLY_CH3:
			begin
				nxt_rdData = mDly_ff[2];
			end
			`GDT_OFF_EDGE_CH1:
			begin
				nxt_rdData = mEdge_ff[0];
			end
			`GDT_OFF_EDGE_CH2:
			begin
				nxt_rdData = mEdge_ff[1];
			end
			`GDT_OFF_EDGE_CH3:
			begin
				nxt_rdData = mEdge_ff[2];
			end
			`GDT_OFF_PART_ID:
			begin
				nxt_rdData = PART_ID;
			end
			default:
			begin
				nxt_hit = 1'b0;
			end
		endcase
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			regRdData <= 16'h0000;
			regHit <= 1'b0;
		end
		else if (regRdEn)
		begin
			regRdData <= nxt_rdData;
			regHit <= nxt_hit;
		end
	end
endmodule // gdt_regs

//--- logic/gdt_consts.vh
// register offsets, field positions, reset values for the gate driver timing bank
// assumes a 5-bit register address and 16-bit data from the serial front end
`ifndef GDT_CONSTS_VH
`define GDT_CONSTS_VH
`define GDT_OFF_FW_TIMING 5'h0d
`define GDT_OFF_DLY_CH1 5'h0e
`define GDT_OFF_DLY_CH2 5'h0f
`define GDT_OFF_DLY_CH3 5'h10
`define GDT_OFF_GENERAL_STATUS 5'h11
`define GDT_OFF_DRAIN_SOURCE_OVERVOLTAGE 5'h12
`define GDT_OFF_HBVOUT 5'h13
`define GDT_OFF_MDLY_CH1 5'h14
`define GDT_OFF_MDLY_CH2 5'h15
`define GDT_OFF_MDLY_CH3 5'h16
`define GDT_OFF_EDGE_CH1 5'h17
`define GDT_OFF_EDGE_CH2 5'h18
`define GDT_OFF_EDGE_CH3 5'h19
`define GDT_OFF_PART_ID 5'h1f
`define GDT_RST_FW_TIMING 16'h4900
`define GDT_RST_DLY 16'h0a0a
`define GDT_RST_STATUS 16'h0000
`define GDT_FW_WRITE_MASK 16'h7fff
`define GDT_BLK4_MSB 14
`define GDT_BLK4_LSB 12
`define GDT_CCP4_MSB 11
`define GDT_CCP4_LSB 9
`define GDT_BLK3_MSB 8
`define GDT_BLK3_LSB 6
`define GDT_TOFF_MSB 15
`define GDT_TOFF_LSB 8
`define GDT_TON_MSB 7
`define GDT_TON_LSB 0
`define GDT_DLY_STEP_PS 62500
`endif

//--- verification/gdt_regs_checker.sv
// assertions on the timing register bank ports
// bound to every gdt_regs instance; one clock domain
`timescale 1ns/1ns
module gdt_regs_checker(
	input wire clk,
	input wire rst,
	input wire regBankSel,
	input wire [4:0] regAddr,
	input wire [15:0] regWrData,
	input wire regWrEn,
	input wire regRdEn,
	input wire [15:0] regRdData,
	input wire regHit,
	input wire [2:0] chargePhaseCh,
	input wire [5:0] activeCurrentCh,
	input wire [7:0] turnonDelayTargetCh1
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_top; regRdEn && regBankSel && regAddr == 5'h0d |=> !regRdData[15]; endproperty
	a_top: assert property (p_top) else $error("fw bit 15 set");
	property p_ton;
		regWrEn && regAddr == 5'h0e |=> turnonDelayTargetCh1 == $past(regWrData[7:0]);
	endproperty
	a_ton: assert property (p_ton) else $error("ton not taken");
	property p_tonRd; regRdEn && regAddr == 5'h0e |=> regRdData[7:0] == $past(turnonDelayTargetCh1);
	endproperty
	a_tonRd: assert property (p_tonRd) else $error("ton readback");
	property p_act; chargePhaseCh == 3'h0 |=> activeCurrentCh == 6'h0; endproperty
	a_act: assert property (p_act) else $error("current outside phase");
	property p_bank; regRdEn && !regBankSel && regAddr == 5'h0d |=> !regHit && regRdData == 16'h0;
	endproperty
	a_bank: assert property (p_bank) else $error("bank 0 hit");
	property p_meas; regRdEn && regAddr >= 5'h14 && regAddr <= 5'h16 |=> regHit; endproperty
	a_meas: assert property (p_meas) else $error("delay miss");
	property p_edge; regRdEn && regAddr >= 5'h17 && regAddr <= 5'h19 |=> regHit; endproperty
	a_edge: assert property (p_edge) else $error("edge miss");
	property p_unmap; regRdEn && regAddr == 5'h1c |=> !regHit && regRdData == 16'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped hit");
endmodule // gdt_regs_checker
bind gdt_regs gdt_regs_checker chk(.clk, .rst, .regBankSel, .regAddr, .regWrData, .regWrEn,
	.regRdEn, .regRdData, .regHit, .chargePhaseCh, .activeCurrentCh, .turnonDelayTargetCh1);

//--- verification/gdt_host.sv
// host model: issues one register access per call
// assumes the bank takes a request on the edge after it is set up
`timescale 1ns/1ns
module gdt_host(
	input wire clk,
	output reg regBankSel,
	output reg [4:0] regAddr,
	output reg [15:0] regWrData,
	output reg regWrEn,
	output reg regRdEn
);
	initial {regBankSel, regAddr, regWrData, regWrEn, regRdEn} = 24'h0;
	task acc(input w, input b, input [4:0] a, input [15:0] d);
	begin
		@(posedge clk);
		regBankSel <= b;
		{regAddr, regWrData} <= {a, d};
		{regWrEn, regRdEn} <= {w, !w};
		@(posedge clk);
		{regWrEn, regRdEn} <= 2'h0;
		// inverted so a stale word never passes for a fresh one
		regWrData <= ~d;
		#1;
	end
	endtask
endmodule // gdt_host

//--- verification/gdt_regs_tb.sv
// self-checking bench for the timing register bank
// host model drives the register port; measurements driven here
`timescale 1ns/1ns
module gdt_regs_tb;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg [47:0] measDelayCh = 48'h0;
	reg [47:0] measEdgeCh = 48'h0;
	reg [2:0] measLoad = 3'h0;
	reg [2:0] chargePhaseCh = 3'h0;
	reg [15:0] genStatusIn = 16'h0e81;
	reg [15:0] dsovIn = 16'hc003;
	reg [15:0] hbvoutIn = 16'h2a50;
	wire regBankSel, regWrEn, regRdEn;
	wire [4:0] regAddr;
	wire [15:0] regWrData;
	integer errorCnt = 0;
	integer checks = 0;
	integer i;
	always #10 clk = ~clk;
	gdt_host host(.clk, .regBankSel, .regAddr, .regWrData, .regWrEn, .regRdEn);
	gdt_regs #(.PART_ID(16'h5a3c)) // arbitrary identity for the test
	uut(.clk, .rst, .regBankSel, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData(),
		.regHit(), .measDelayCh, .measEdgeCh, .measLoad, .genStatusIn, .dsovIn,
		.hbvoutIn, .freewheelBlankTimeSlot4(), .freewheelCrosscurrentTimeSlot4(),
		.freewheelBlankTimeSlot3(), .peakDriveCurrentCh1(), .peakDriveCurrentCh2(),
		.peakDriveCurrentCh3(), .chargePhaseCh, .activeCurrentCh(), .turnoffDelayTargetCh1(),
		.turnoffDelayTargetCh2(), .turnoffDelayTargetCh3(), .turnonDelayTargetCh1(),
		.turnonDelayTargetCh2(), .turnonDelayTargetCh3());
	task chk(input [47:0] nm, input [15:0] s, input [15:0] e);
	begin
		checks = checks + 1;
		if (s !== e)
		begin
			errorCnt = errorCnt + 1;
			$display("mismatch %0s exp %h seen %h", nm, e, s);
		end
	end
	endtask
	task rd(input b, input [4:0] a, input [15:0] e);
	begin
		host.acc(1'b0, b, a, 16'h0);
		chk("rdata", uut.regRdData, e);
	end
	endtask
	task give_verdict;
	begin
		$display("checks %0d mismatches %0d", checks, errorCnt);
		if (errorCnt == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	end
	endtask
	initial
	begin
		#20000;
		errorCnt = errorCnt + 1;
		give_verdict;
	end
	initial
	begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(1'b1, 5'h0d, 16'h4900);
		for (i = 0; i < 3; i = i + 1)
		begin
			rd(1'b1, 5'h0e + i[4:0], 16'h0a0a);
			rd(1'b1, 5'h14 + i[4:0], 16'h0);
			rd(1'b1, 5'h17 + i[4:0], 16'h0);
		end
		$display("reset test done");
		host.acc(1'b1, 1'b1, 5'h0d, 16'hffff);
		rd(1'b1, 5'h0d, 16'h7fff);
		chk("blk4", {13'h0, uut.freewheelBlankTimeSlot4}, 16'h7);
		chk("ccp4", {13'h0, uut.freewheelCrosscurrentTimeSlot4}, 16'h7);
		chk("blk3", {13'h0, uut.freewheelBlankTimeSlot3}, 16'h7);
		host.acc(1'b1, 1'b0, 5'h0d, 16'h1111);
		rd(1'b0, 5'h0d, 16'h0);
		chk("hit", {15'h0, uut.regHit}, 16'h0);
		host.acc(1'b1, 1'b1, 5'h0d, 16'h8039);
		rd(1'b1, 5'h0d, 16'h0039);
		chk("pk1", {14'h0, uut.peakDriveCurrentCh1}, 16'h1);
		chk("pk2", {14'h0, uut.peakDriveCurrentCh2}, 16'h2);
		chk("pk3", {14'h0, uut.peakDriveCurrentCh3}, 16'h3);
		rd(1'b1, 5'h1c, 16'h0);
		chk("hit", {15'h0, uut.regHit}, 16'h0);
		rd(1'b1, 5'h11, 16'h0e81);
		rd(1'b1, 5'h12, 16'hc003);
		rd(1'b1, 5'h13, 16'h2a50);
		rd(1'b1, 5'h1f, 16'h5a3c);
		$display("freewheel test done");
		for (i = 0; i < 3; i = i + 1)
			host.acc(1'b1, 1'b1, 5'h0e + i[4:0], {8'hff - i[7:0], i[7:0]});
		chk("toff2", {8'h0, uut.turnoffDelayTargetCh2}, 16'hfe);
		chk("ton3", {8'h0, uut.turnonDelayTargetCh3}, 16'h2);
		chk("toff1", {8'h0, uut.turnoffDelayTargetCh1}, 16'hff);
		chk("toff3", {8'h0, uut.turnoffDelayTargetCh3}, 16'hfd);
		chk("ton1", {8'h0, uut.turnonDelayTargetCh1}, 16'h0);
		chk("ton2", {8'h0, uut.turnonDelayTargetCh2}, 16'h1);
		rd(1'b1, 5'h0f, 16'hfe01);
		@(posedge clk);
		measDelayCh <= {16'h3333, 16'h2222, 16'h1111};
		measEdgeCh <= {16'h6666, 16'h5555, 16'h4444};
		measLoad <= 3'h7;
		@(posedge clk);
		measLoad <= 3'h0;
		for (i = 0; i < 3; i = i + 1)
		begin
			rd(1'b1, 5'h14 + i[4:0], measDelayCh[16 * i +: 16]);
			rd(1'b1, 5'h17 + i[4:0], measEdgeCh[16 * i +: 16]);
		end
		chk("hit", {15'h0, uut.regHit}, 16'h1);
		$display("measure test done");
		@(posedge clk);
		chargePhaseCh <= 3'h5;
		repeat (2) @(posedge clk);
		#1;
		chk("cur", {10'h0, uut.activeCurrentCh}, 16'h31);
		$display("phase test done");
		give_verdict;
	end
endmodule // gdt_regs_tb
